// >>> pkg/mls_pkg.sv
package mls_pkg;
    // clock and timing, figures in their own units
    localparam int CLK_HZ = 25_000_000; // pclk rate
    localparam int LCK_DET_US = 500; // lock detect duration in us
    localparam int LCK_DET_CYC = LCK_DET_US * (CLK_HZ / 1_000_000);
    localparam int LOCK_OFF_MS = 5000; // off time before a retry in ms
    localparam int LOCK_OFF_CYC = LOCK_OFF_MS * (CLK_HZ / 1_000);
    localparam int BRAKE_UNIT_US = 10; // brake settle step per code in us
    localparam int BRAKE_UNIT_CYC = BRAKE_UNIT_US * (CLK_HZ / 1_000_000);
    // current scaling of the power stage estimate
    localparam int CUR_LSB_MA = 10; // one current count in mA
    localparam int NOMOTOR_MA = 140; // no-motor current floor
    localparam logic [11:0] NOMOTOR_CNT = 12'(NOMOTOR_MA / CUR_LSB_MA);
    localparam int SOFT_LIM_SHIFT = 2; // soft limit code to current counts
    localparam int HARD_TRIP_SHIFT = 6; // trip code to current counts
    localparam int BRAKE_CUR_SHIFT = 4; // brake threshold code to counts
    localparam int EST_SHIFT = 6; // fixed point of products
    // register byte offsets
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_MOTOR = 12'h004;
    localparam logic [11:0] ADDR_ENABLE = 12'h008;
    localparam logic [11:0] ADDR_FAULT = 12'h00C;
    localparam logic [11:0] ADDR_STATUS = 12'h010;
    // field positions
    localparam int CTRL_SOFT_LSB = 0; // soft_current_limit_threshold[3:0]
    localparam int CTRL_HARD_LSB = 4; // hard_current_trip_threshold[2:0]
    localparam int CTRL_WIN_LSB = 8; // constant_window_select[1:0]
    localparam int MOTOR_RES_LSB = 0; // winding_resistance_setting[6:0]
    localparam int MOTOR_KT_LSB = 8; // programmed_bemf_constant[6:0]
    localparam int EN_LOCK_LSB = 0; // lock_scheme_enables[5:0]
    localparam int EN_MECH_BIT = 8; // mechanical_surge_guard_enable
    localparam int EN_IND_BIT = 9; // inductive_surge_guard_enable
    localparam int EN_MODE_BIT = 10; // mechanical_surge_guard_mode
    localparam int EN_SETTLE_LSB = 12; // brake_settle_time_select[2:0]
    localparam int EN_BRKCUR_LSB = 16; // brake_current_threshold[2:0]
    localparam int FLAG_OCP_BIT = 6; // overcurrent_shutdown flag
    // write masks and reset values
    localparam logic [31:0] CTRL_MASK = 32'h0000_037F;
    localparam logic [31:0] MOTOR_MASK = 32'h0000_7F7F;
    localparam logic [31:0] EN_MASK = 32'h0007_773F;
    localparam logic [31:0] CTRL_RST = 32'h0000_0034;
    localparam logic [31:0] MOTOR_RST = 32'h0000_2828;
    localparam logic [31:0] EN_RST = 32'h0001_333F;

    // supervisor states, one hot
    typedef enum logic [3:0] {
        MLS_RUN = 4'b0001,
        MLS_BRAKE = 4'b0010,
        MLS_OFF = 4'b0100,
        MLS_RESTART = 4'b1000
    } mls_state_e;

    // estimates and events from the commutation core and power stage
    typedef struct packed {
        logic closed_loop; // level: closed-loop control
        logic handoff; // pulse: open to closed loop handoff
        logic ol_rate_over; // level: open-loop rate above handoff
        logic bemf_seen; // pulse: bemf detected
        logic elec_cycle; // pulse: one electrical cycle of drive
        logic zero_cross; // pulse: commutation edge
        logic half_cycle; // pulse: new measured constant
        logic ocp_trip; // level: short circuit comparator
        logic vcc_at_24v; // level: supply reached 24 V
        logic [11:0] amp_req; // requested amplitude
        logic [11:0] speed; // electrical speed
        logic signed [11:0] phase_u_cur; // phase u current
        logic [11:0] lowside_cur; // low-side driver current
        logic [11:0] kt_measured; // integrated bemf per half cycle
    } mls_stage_s;

    // commands to the output stage
    typedef struct packed {
        logic drive_en; // phases driven
        logic brake_lowside; // high sides off, all low sides on
        logic hiz; // all phases high impedance
        logic restart; // pulse: start a new spin-up
        logic [11:0] amp_out; // limited amplitude
    } mls_drive_s;
endpackage

// >>> core/mls_supervisor.sv
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
module mls_supervisor #(
    parameter int LCK_DET_CYC = mls_pkg::LCK_DET_CYC,
    parameter int LOCK_OFF_CYC = mls_pkg::LOCK_OFF_CYC,
    parameter int BRAKE_UNIT_CYC = mls_pkg::BRAKE_UNIT_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire mls_pkg::mls_stage_s stage,
    output mls_pkg::mls_drive_s drive
);
    import mls_pkg::*;

    logic [31:0] ctrl_reg; // limits and window select
    logic [31:0] motor_reg; // resistance and constant
    logic [31:0] en_reg; // enables and brake settings
    logic [6:0] fault_reg; // lock flags plus overcurrent
    logic [6:0] fault_next;
    mls_state_e state_reg;
    logic [31:0] off_cnt_reg; // off interval counter
    logic [31:0] brk_cnt_reg; // brake settle counter
    logic [11:0] amp_out_reg;
    logic [11:0] amp_next;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic kt_out_reg; // last measured constant outside window
    logic [1:0] ol_stage_reg; // 0 idle, 1 armed, 2 timing, 3 done
    logic [19:0] per_cnt_reg; // cycles since last commutation
    logic [19:0] per_prev_reg; // previous commutation period
    logic [5:0] cond; // lock conditions this cycle
    logic [1:0] dur_raw; // abnormal_speed_flag and abnormal_constant_flag raw conditions
    logic [1:0] dur_hit; // raw held for the detect duration

    // configuration fields
    logic [3:0] soft_thr;
    logic [2:0] hard_thr;
    logic [1:0] win_sel;
    logic [10:0] res_val;
    logic [10:0] kt_val;
    logic [5:0] lock_en;
    logic [2:0] settle_sel;
    logic [2:0] brk_cur;

    // 7-bit code is a 4-bit mantissa shifted left by a 3-bit count
    function automatic logic [10:0] mls_scale(input logic [6:0] code);
        return 11'(code[3:0]) << code[6:4];
    endfunction

    assign soft_thr = ctrl_reg[CTRL_SOFT_LSB +: 4];
    assign hard_thr = ctrl_reg[CTRL_HARD_LSB +: 3];
    assign win_sel = ctrl_reg[CTRL_WIN_LSB +: 2];
    assign res_val = mls_scale(motor_reg[MOTOR_RES_LSB +: 7]);
    assign kt_val = mls_scale(motor_reg[MOTOR_KT_LSB +: 7]);
    assign lock_en = en_reg[EN_LOCK_LSB +: 6];
    assign settle_sel = en_reg[EN_SETTLE_LSB +: 3];
    assign brk_cur = en_reg[EN_BRKCUR_LSB +: 3];

    logic running;
    assign running = (state_reg == MLS_RUN);

    // amplitude path
    logic [5:0] ilim; // limit current in counts
    logic [16:0] prod_ir;
    logic [22:0] prod_kt;
    logic [23:0] vlim_full;
    logic [17:0] vlim; // soft limit amplitude
    logic [16:0] bemf_spd; // bemf from speed and constant
    logic [11:0] capped;
    logic soft_active;
    logic floor_on;
    assign ilim = 6'({2'b00, soft_thr} << SOFT_LIM_SHIFT);
    assign prod_ir = 17'(ilim) * 17'(res_val);
    assign prod_kt = 23'(stage.speed) * 23'(kt_val);
    assign vlim_full = 24'(prod_ir) + 24'(prod_kt);
    assign vlim = 18'(vlim_full >> EST_SHIFT);
    assign bemf_spd = 17'(prod_kt >> EST_SHIFT);
    // no current is measured here; the cap is purely computed
    assign soft_active = stage.closed_loop && (18'(stage.amp_req) > vlim);
    assign capped = soft_active ? vlim[11:0] : stage.amp_req;
    assign floor_on = en_reg[EN_MECH_BIT]
        && (!en_reg[EN_MODE_BIT] || stage.vcc_at_24v);

    // floor wins over the soft cap: a surge is worse than overshoot
    always_comb begin
        amp_next = capped;
        if (floor_on && (17'(capped) < bemf_spd)) begin
            amp_next = (bemf_spd > 17'(12'hFFF)) ? 12'hFFF : bemf_spd[11:0];
        end
    end

    // amplitude register, zero while not driving
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            amp_out_reg <= 12'h000;
        end else begin
            amp_out_reg <= running ? amp_next : 12'h000;
        end
    end

    // bemf from phase u current: applied amplitude minus i*r
    logic [11:0] abs_iu;
    logic signed [23:0] iu_r;
    logic signed [24:0] bemf_cur;
    logic signed [24:0] amp_far;
    assign abs_iu = stage.phase_u_cur[11] ? 12'(-stage.phase_u_cur) : stage.phase_u_cur;
    assign iu_r = stage.phase_u_cur * $signed({1'b0, res_val});
    assign bemf_cur = $signed(25'(amp_out_reg)) - 25'(iu_r >>> EST_SHIFT);
    assign amp_far = $signed(25'(amp_out_reg) + 25'(amp_out_reg >> 1));

    // constant window around the programmed value
    logic [10:0] win_half;
    logic [11:0] win_lo;
    logic [11:0] win_hi;
    assign win_half = 11'(kt_val >> (3'(win_sel) + 3'd1));
    assign win_lo = 12'(kt_val) - 12'(win_half);
    assign win_hi = 12'(kt_val) + 12'(win_half);

    // latch window result once per half electrical cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            kt_out_reg <= 1'b0;
        end else if (!running || !stage.closed_loop) begin
            kt_out_reg <= 1'b0;
        end else if (stage.half_cycle) begin
            kt_out_reg <= (stage.kt_measured < win_lo)
                || (stage.kt_measured > win_hi);
        end
    end

    assign dur_raw[0] = running && stage.closed_loop && (bemf_cur > amp_far);
    assign dur_raw[1] = running && kt_out_reg;

    // sustained-condition timers for abnormal_speed_flag and abnormal_constant_flag
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_dur
            logic [31:0] cnt_reg;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cnt_reg <= 32'h0000_0000;
                end else if (!dur_raw[gi]) begin
                    cnt_reg <= 32'h0000_0000;
                end else if (cnt_reg < 32'(LCK_DET_CYC)) begin
                    cnt_reg <= cnt_reg + 32'h0000_0001;
                end
            end
            assign dur_hit[gi] = dur_raw[gi] && (cnt_reg >= 32'(LCK_DET_CYC) - 32'h0000_0001);
        end
    endgenerate

    // open-loop stuck: arm at rate threshold, time one full cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ol_stage_reg <= 2'b00;
        end else if (!running || stage.closed_loop) begin
            ol_stage_reg <= 2'b00;
        end else if (stage.bemf_seen) begin
            ol_stage_reg <= 2'b11; // bemf found, start is healthy
        end else if (ol_stage_reg == 2'b00 && stage.ol_rate_over) begin
            ol_stage_reg <= 2'b01;
        end else if (ol_stage_reg == 2'b01 && stage.elec_cycle) begin
            ol_stage_reg <= 2'b10; // a partial first cycle is not counted
        end
    end

    // closed-loop commutation period tracking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            per_cnt_reg <= 20'h0_0000;
            per_prev_reg <= 20'h0_0000;
        end else if (!running || !stage.closed_loop) begin
            per_cnt_reg <= 20'h0_0000;
            per_prev_reg <= 20'h0_0000;
        end else if (stage.zero_cross) begin
            per_prev_reg <= per_cnt_reg;
            per_cnt_reg <= 20'h0_0000;
        end else if (per_cnt_reg != 20'hF_FFFF) begin
            per_cnt_reg <= per_cnt_reg + 20'h0_0001;
        end
    end

    // conditions; flags follow these regardless of enables
    assign cond[0] = running
        && (stage.lowside_cur > 12'((12'(hard_thr) + 12'h001) << HARD_TRIP_SHIFT));
    assign cond[1] = dur_hit[0];
    assign cond[2] = dur_hit[1];
    assign cond[3] = running && stage.handoff && (abs_iu <= NOMOTOR_CNT);
    assign cond[4] = running && (ol_stage_reg == 2'b10) && stage.elec_cycle
        && !stage.bemf_seen;
    assign cond[5] = running && stage.closed_loop && (per_prev_reg != 20'h0_0000)
        && (21'(per_cnt_reg) > {per_prev_reg, 1'b0});

    // one shared trip: enabled lock or overcurrent, never the soft cap
    logic trip;
    assign trip = running && ((|(cond & lock_en)) || stage.ocp_trip);

    // set wins over the restart clear
    assign fault_next = ((state_reg == MLS_RESTART) ? 7'h00 : fault_reg)
        | {stage.ocp_trip, cond};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_reg <= 7'h00;
        end else begin
            fault_reg <= fault_next;
        end
    end

    // brake exit condition
    logic brk_quiet;
    logic [31:0] brk_target;
    assign brk_quiet = abs_iu < 12'((12'(brk_cur) + 12'h001) << BRAKE_CUR_SHIFT);
    assign brk_target = 32'(BRAKE_UNIT_CYC) * 32'(settle_sel);

    // fault sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= MLS_RUN;
        end else begin
            unique case (state_reg)
                MLS_RUN: begin
                    if (trip) begin
                        // code 000 means no brake at all
                        state_reg <= (en_reg[EN_IND_BIT] && settle_sel != 3'b000)
                            ? MLS_BRAKE : MLS_OFF;
                    end
                end
                MLS_BRAKE: begin
                    if (brk_quiet && brk_cnt_reg + 32'h0000_0001 >= brk_target) begin
                        state_reg <= MLS_OFF;
                    end
                end
                MLS_OFF: begin
                    if (off_cnt_reg >= 32'(LOCK_OFF_CYC) - 32'h0000_0001) begin
                        state_reg <= MLS_RESTART;
                    end
                end
                MLS_RESTART: begin
                    state_reg <= MLS_RUN;
                end
            endcase
        end
    end

    // brake settle timer restarts whenever current rises again
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brk_cnt_reg <= 32'h0000_0000;
        end else if (state_reg != MLS_BRAKE || !brk_quiet) begin
            brk_cnt_reg <= 32'h0000_0000;
        end else begin
            brk_cnt_reg <= brk_cnt_reg + 32'h0000_0001;
        end
    end

    // off interval timer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            off_cnt_reg <= 32'h0000_0000;
        end else if (state_reg != MLS_OFF) begin
            off_cnt_reg <= 32'h0000_0000;
        end else begin
            off_cnt_reg <= off_cnt_reg + 32'h0000_0001;
        end
    end

    assign drive.drive_en = running;
    assign drive.brake_lowside = (state_reg == MLS_BRAKE);
    assign drive.hiz = (state_reg == MLS_OFF) || (state_reg == MLS_RESTART);
    assign drive.restart = (state_reg == MLS_RESTART);
    assign drive.amp_out = amp_out_reg;

    // apb: zero wait, data latched in the setup phase
    logic wr_en;
    logic mapped;
    logic [31:0] rd_mux;
    assign wr_en = psel && penable && pwrite;
    assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_MOTOR) || (paddr == ADDR_ENABLE)
        || (paddr == ADDR_FAULT) || (paddr == ADDR_STATUS);

    always_comb begin
        unique case (paddr)
            ADDR_CTRL: rd_mux = ctrl_reg;
            ADDR_MOTOR: rd_mux = motor_reg;
            ADDR_ENABLE: rd_mux = en_reg;
            ADDR_FAULT: rd_mux = 32'(fault_reg);
            ADDR_STATUS: rd_mux = {12'h000, amp_out_reg, 2'b00, soft_active,
                stage.closed_loop, 4'(state_reg)};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // configuration writes; fault and status are read only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RST;
            motor_reg <= MOTOR_RST;
            en_reg <= EN_RST;
        end else if (wr_en) begin
            if (paddr == ADDR_CTRL) ctrl_reg <= pwdata & CTRL_MASK;
            if (paddr == ADDR_MOTOR) motor_reg <= pwdata & MOTOR_MASK;
            if (paddr == ADDR_ENABLE) en_reg <= pwdata & EN_MASK;
        end
    end

    // read data and error captured at setup, held through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (psel && !penable) begin
            prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr_reg <= !mapped;
        end
    end

    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg && psel && penable;
    assign pready = 1'b1;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    ocp_stop_a: assert property (running && stage.ocp_trip |=> !drive.drive_en)
        else $error("overcurrent did not stop drive");
    flag_set_a: assert property (cond != 6'h00
        |=> (fault_reg[5:0] & $past(cond)) == $past(cond)) else $error("lock flag not set");
    restart_clear_a: assert property (state_reg == MLS_RESTART && cond == 6'h00
        |=> fault_reg[5:0] == 6'h00) else $error("lock flags not cleared on restart");
    off_hiz_a: assert property (state_reg == MLS_OFF |-> drive.hiz && !drive.drive_en)
        else $error("outputs not high impedance in off");
    off_wait_a: assert property (state_reg == MLS_OFF
        && off_cnt_reg < 32'(LOCK_OFF_CYC) - 32'h0000_0001 |=> state_reg == MLS_OFF)
        else $error("off interval cut short");
    soft_no_fault_a: assert property (soft_active && running && cond == 6'h00
        && !stage.ocp_trip |=> drive.drive_en) else $error("soft limit stopped the motor");
    soft_cap_a: assert property (running && !floor_on && stage.closed_loop
        |=> 18'(amp_out_reg) <= $past(vlim)) else $error("amplitude above soft limit");
    open_loop_a: assert property (running && !floor_on && !stage.closed_loop
        |=> amp_out_reg == $past(stage.amp_req)) else $error("limit applied in open loop");
    trip_flag_a: assert property (cond[0] && lock_en[0]
        |=> fault_reg[0] && (drive.brake_lowside || drive.hiz)) else $error("trip missed");
    no_motor_a: assert property (cond[3] |=> fault_reg[3])
        else $error("no-motor flag not set");
    stuck_cl_a: assert property (cond[5] && lock_en[5] |=> !drive.drive_en)
        else $error("closed-loop stuck not acted on");

    brake_seen_c: cover property (running && trip ##1 state_reg == MLS_BRAKE);
    retry_seen_c: cover property (state_reg == MLS_RESTART ##1 running);
    soft_seen_c: cover property (soft_active && running [*3]);
    masked_flag_c: cover property (cond[4] && !lock_en[4] ##1 running);
endmodule // mls_supervisor

// >>> test/mls_stage_model.sv
`timescale 1ns/1ps
// power stage and motor: current follows the drive, decays in brake
module mls_stage_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] cur_cmd,
    input wire logic [11:0] amp_cmd,
    input wire logic ocp_cmd,
    input wire logic cl_cmd,
    input wire logic hand_cmd,
    input wire mls_pkg::mls_drive_s drive,
    output mls_pkg::mls_stage_s stage
);
    import mls_pkg::*;
    logic [11:0] cur_reg; // winding current
    // winding current halves each cycle with low sides on, none in high-z
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_reg <= 12'h000;
        end else if (drive.drive_en) begin
            cur_reg <= cur_cmd;
        end else if (drive.brake_lowside) begin
            cur_reg <= cur_reg >> 1;
        end else begin
            cur_reg <= 12'h000;
        end
    end
    // estimates seen by the supervisor, other events stay quiet
    always_comb begin
        stage = '0;
        stage.closed_loop = cl_cmd;
        stage.handoff = hand_cmd;
        stage.amp_req = amp_cmd;
        stage.ocp_trip = ocp_cmd;
        stage.phase_u_cur = cur_reg;
        stage.lowside_cur = cur_reg;
    end
endmodule // mls_stage_model

// >>> test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import mls_pkg::*;
    localparam int OFF_N = 30; // shortened off time
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0, cur_cmd = '0, amp_cmd = '0, ec;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, er, ocp_cmd = 0, cl_cmd = 0, hand_cmd = 0;
    logic [15:0] lf = 16'h3887; // lfsr seed
    mls_stage_s stage;
    mls_drive_s drive;
    int fails = 0, samples_checked = 0, cyc = 0;
    always #20 pclk = ~pclk;
    mls_supervisor #(.LCK_DET_CYC(20), .LOCK_OFF_CYC(OFF_N), .BRAKE_UNIT_CYC(4)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .stage(stage), .drive(drive));
    mls_stage_model u_stage (.pclk(pclk), .presetn(presetn), .cur_cmd(cur_cmd), .amp_cmd(amp_cmd),
        .ocp_cmd(ocp_cmd), .cl_cmd(cl_cmd), .hand_cmd(hand_cmd), .drive(drive), .stage(stage));
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    // soft cap at zero speed: limit current times winding resistance
    function automatic logic [11:0] exp_cap(input logic [3:0] thr, input logic [6:0] rc);
        int cur;
        int res;
        cur = int'(thr) << SOFT_LIM_SHIFT;
        res = int'(rc[3:0]) << rc[6:4];
        return 12'((cur * res) >> EST_SHIFT);
    endfunction
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 6000) begin
            fails++;
            finish_test();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask
    // one apb transfer, held until pready is sampled
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(0, a, 32'h0000_0000);
        chk(nm, e, rd);
    endtask
    task automatic pulse_handoff(input logic [11:0] c);
        cur_cmd <= c;
        repeat (2) @(posedge pclk);
        hand_cmd <= 1;
        @(posedge pclk);
        hand_cmd <= 0;
        repeat (3) @(posedge pclk);
    endtask
    // trip, brake, off, restart, flags cleared
    task automatic fault_seq(input logic [31:0] flags);
        int n;
        int r;
        n = 0;
        r = 0;
        while (drive.drive_en === 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        chk("drive_en", 0, drive.drive_en);
        chk("brake_lowside", 1, drive.brake_lowside);
        cur_cmd <= 12'h000;
        ocp_cmd <= 0;
        rdchk("fault", ADDR_FAULT, flags);
        n = 0;
        while (drive.hiz !== 1'b1 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        n = 0;
        while (drive.hiz === 1'b1 && n < 200) begin
            r += (drive.restart === 1'b1);
            @(posedge pclk);
            n++;
        end
        chk("hiz cycles", OFF_N + 1, n);
        chk("restart pulses", 1, r);
        rdchk("fault after restart", ADDR_FAULT, 32'h0000_0000);
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        rdchk("ctrl rst", ADDR_CTRL, CTRL_RST);
        rdchk("motor rst", ADDR_MOTOR, MOTOR_RST);
        rdchk("enable rst", ADDR_ENABLE, EN_RST);
        apb(1, 12'h014, 32'hFFFF_FFFF);
        chk("unmapped err", 1, er);
        apb(1, ADDR_FAULT, 32'hFFFF_FFFF);
        rdchk("fault ro", ADDR_FAULT, 32'h0000_0000);
        repeat (4) begin
            lf = lfsr(lf);
            apb(1, ADDR_CTRL, {16'h0000, lf});
            rdchk("ctrl rw", ADDR_CTRL, {16'h0000, lf} & CTRL_MASK);
        end
        apb(1, ADDR_CTRL, CTRL_RST); // trip level above soft limit
        cur_cmd <= 12'h100;
        repeat (5) @(posedge pclk);
        chk("no trip at level", 1, drive.drive_en);
        cur_cmd <= 12'h101;
        fault_seq(32'h0000_0001);
        apb(1, ADDR_ENABLE, EN_RST & ~32'h0000_0001);
        cur_cmd <= 12'h101;
        repeat (5) @(posedge pclk);
        chk("disabled keeps drive", 1, drive.drive_en);
        cur_cmd <= 12'h000;
        rdchk("flag when disabled", ADDR_FAULT, 32'h0000_0001);
        apb(1, ADDR_ENABLE, 32'h0001_3300);
        ocp_cmd <= 1;
        fault_seq(32'h0000_0041);
        cl_cmd <= 1;
        pulse_handoff(12'h00F);
        rdchk("motor present", ADDR_FAULT, 32'h0000_0000);
        pulse_handoff(12'h00E);
        rdchk("no motor", ADDR_FAULT, 32'h0000_0008);
        chk("no motor disabled", 1, drive.drive_en);
        apb(1, ADDR_ENABLE, 32'h0001_3308);
        pulse_handoff(12'h00E);
        fault_seq(32'h0000_0008);
        // soft cap with the speed floor off, random resistance code
        apb(1, ADDR_ENABLE, 32'h0001_3200);
        lf = lfsr(lf);
        apb(1, ADDR_MOTOR, {25'h000_0000, lf[6:0]});
        ec = exp_cap(CTRL_RST[3:0], lf[6:0]);
        amp_cmd <= 12'hFFF;
        repeat (3) @(posedge pclk);
        chk("amp capped", ec, drive.amp_out);
        chk("cap keeps drive", 1, drive.drive_en);
        rdchk("status", ADDR_STATUS, {12'h000, ec, 8'h31});
        rdchk("no cap fault", ADDR_FAULT, 32'h0000_0000);
        cl_cmd <= 0;
        repeat (3) @(posedge pclk);
        chk("amp open loop", 32'h0000_0FFF, drive.amp_out);
        finish_test();
    end
endmodule // tb_top
